// ===== hdl/qdsc_pkg.sv
// Purpose: shared constants for the quad converter serial control ends
// Assumes: 24-bit frames, four channels of 14-bit codes
// Notes: frame bit positions count from the last bit shifted in
package qdsc_pkg;
  // ----------------------------------------------------------------
  // frame layout
  // ----------------------------------------------------------------
  localparam int QDSC_FRAME_W = 24;
  localparam int QDSC_CODE_W = 14;
  localparam int QDSC_NCH = 4;
  localparam int QDSC_ADDR_HI = 23;
  localparam int QDSC_ADDR_LO = 22;
  localparam int QDSC_CMD_HI = 21;
  localparam int QDSC_CMD_LO = 20;
  localparam int QDSC_ZERO_BIT = 19;
  localparam int QDSC_SEL_HI = 18;
  localparam int QDSC_SEL_LO = 17;
  localparam int QDSC_PD_BIT = 16;
  localparam int QDSC_CODE_HI = 15;
  localparam int QDSC_CODE_LO = 2;
  localparam logic [4:0] QDSC_LAST_FALL = 5'h18;
  // load commands
  localparam logic [1:0] QDSC_LD_STORE = 2'h0;
  localparam logic [1:0] QDSC_LD_UPDATE = 2'h1;
  localparam logic [1:0] QDSC_LD_SIMUL = 2'h2;
  localparam logic [1:0] QDSC_LD_BCAST = 2'h3;
  // channel operating modes {flag, mode_hi, mode_lo}
  localparam logic [2:0] QDSC_MODE_NORMAL = 3'h0;
  localparam logic [2:0] QDSC_MODE_1K = 3'h5;
  localparam logic [2:0] QDSC_MODE_100K = 3'h6;
  localparam logic [2:0] QDSC_MODE_HIZ = 3'h7;
  // ----------------------------------------------------------------
  // host timing and registers
  // ----------------------------------------------------------------
  localparam logic [4:0] QDSC_SCLK_HALF = 5'h10;
  localparam logic [3:0] QDSC_REG_FRAME = 4'h0;
  localparam logic [3:0] QDSC_REG_STATUS = 4'h4;
  localparam logic [3:0] QDSC_REG_PINS = 4'h8;
  localparam int QDSC_PIN_MUTE = 0;
  localparam int QDSC_PIN_STROBE = 1;
endpackage

// ===== hdl/qdsc_link_if.sv
// Purpose: serial link between host master and converter control
// Assumes: all signals are plain one-way levels
// Notes: the host drives every line at all times
`timescale 1ns/1ps
interface qdsc_link_if;
  logic sclk;
  logic frame_sync_n;
  logic ser_data;
  logic port_mute;
  logic async_load_strobe;
  modport host (
    output sclk,
    output frame_sync_n,
    output ser_data,
    output port_mute,
    output async_load_strobe
  );
  modport dev (
    input sclk,
    input frame_sync_n,
    input ser_data,
    input port_mute,
    input async_load_strobe
  );
endinterface

// ===== hdl/qdsc_dev.sv
// Purpose: converter-side serial command decoder with double buffers
// Assumes: link slow against i_clk, all pins pass two flops first
// Notes: one packed state struct, one comb copy, one register
// Behaviour
// - 24-bit frame: address, command, channel, flag, code
// - command 00 stores, 01 stores and loads
// - broadcast command acts regardless of address
// - command 10 stores then loads all
// - command 10 with flag stores power-down mode
// - broadcast, bit 18 set: all take frame
// - update happens on 24th falling clock edge
// - early sync rise clears shift register
// - aborted frame changes no state
// - converter registers clear to zero at reset
// - internal reference enabled after reset
// - host ties strobe low when unused
// - strobe rising edge loads all from buffers
// - host fills buffers with store frames first
// - unchanged buffer keeps output unchanged on strobe
// - mute high ignores serial port
// - mode from flag and two mode bits
// - flag zero normal; 101,110,111 power-down modes
// - power-down codes travel like data
// - power-down leaves converter register untouched
`timescale 1ns/1ps
module qdsc_dev
  import qdsc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  qdsc_link_if.dev link,
  input wire logic i_dev_addr_hi,
  input wire logic i_dev_addr_lo,
  output logic [QDSC_NCH*QDSC_CODE_W-1:0] o_dac_code,
  output logic [QDSC_NCH*3-1:0] o_chan_mode,
  output logic o_ref_enabled,
  output logic o_frame_done
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] sclk_s;
    logic [1:0] sync_s;
    logic [1:0] data_s;
    logic [1:0] mute_s;
    logic [1:0] strobe_s;
    logic [1:0] addr_hi_s;
    logic [1:0] addr_lo_s;
    logic sclk_prev;
    logic strobe_prev;
    logic [QDSC_FRAME_W-2:0] input_shift_word;
    logic [4:0] fall_cnt;
    logic [QDSC_NCH-1:0] buf_pd;
    logic [QDSC_NCH-1:0][QDSC_CODE_W-1:0] buf_code;
    logic [QDSC_NCH-1:0][QDSC_CODE_W-1:0] dac_code;
    logic [QDSC_NCH-1:0][2:0] dac_mode;
    logic ref_en;
    logic done;
  } qdsc_dev_t;

  qdsc_dev_t st_reg;
  qdsc_dev_t st_next;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // sampled links are read only from the second flop of each chain
  always_comb begin
    logic [QDSC_FRAME_W-1:0] w;
    logic [1:0] cmd;
    logic [1:0] sel;
    logic hit;
    logic fall;
    logic [QDSC_NCH-1:0] load;
    fall = st_reg.sclk_prev & ~st_reg.sclk_s[1];
    st_next = st_reg;
    w = '0;
    cmd = '0;
    sel = '0;
    hit = 1'b0;
    load = '0;
    st_next.sclk_s = {st_reg.sclk_s[0], link.sclk};
    st_next.sync_s = {st_reg.sync_s[0], link.frame_sync_n};
    st_next.data_s = {st_reg.data_s[0], link.ser_data};
    st_next.mute_s = {st_reg.mute_s[0], link.port_mute};
    st_next.strobe_s = {st_reg.strobe_s[0], link.async_load_strobe};
    st_next.addr_hi_s = {st_reg.addr_hi_s[0], i_dev_addr_hi};
    st_next.addr_lo_s = {st_reg.addr_lo_s[0], i_dev_addr_lo};
    st_next.sclk_prev = st_reg.sclk_s[1];
    st_next.strobe_prev = st_reg.strobe_s[1];
    st_next.done = 1'b0;

    // serial port: mute or idle sync drop the partial frame
    if (st_reg.mute_s[1] | st_reg.sync_s[1]) begin
      st_next.input_shift_word = '0;
      st_next.fall_cnt = '0;
    end else if (fall && st_reg.fall_cnt != QDSC_LAST_FALL) begin
      // msb first; extra edges past the 24th are ignored
      st_next.input_shift_word = {st_reg.input_shift_word[QDSC_FRAME_W-3:0],
        st_reg.data_s[1]};
      st_next.fall_cnt = st_reg.fall_cnt + 5'h01;
      if (st_reg.fall_cnt == QDSC_LAST_FALL - 5'h01) begin
        w = {st_reg.input_shift_word, st_reg.data_s[1]};
        cmd = w[QDSC_CMD_HI:QDSC_CMD_LO];
        sel = w[QDSC_SEL_HI:QDSC_SEL_LO];
        // a frame with the reserved bit set is not acted on
        hit = ~w[QDSC_ZERO_BIT] & ((cmd == QDSC_LD_BCAST) |
          (w[QDSC_ADDR_HI:QDSC_ADDR_LO] == {st_reg.addr_hi_s[1], st_reg.addr_lo_s[1]}));
      end
    end

    // decode of a complete, addressed frame
    if (hit) begin
      st_next.done = 1'b1;
      case (cmd)
        QDSC_LD_STORE, QDSC_LD_UPDATE, QDSC_LD_SIMUL: begin
          st_next.buf_pd[sel] = w[QDSC_PD_BIT];
          st_next.buf_code[sel] = w[QDSC_CODE_HI:QDSC_CODE_LO];
          if (cmd == QDSC_LD_UPDATE) begin
            load[sel] = 1'b1;
          end else if (cmd == QDSC_LD_SIMUL) begin
            load = '1;
          end
        end
        QDSC_LD_BCAST: begin
          if (w[QDSC_SEL_HI]) begin
            st_next.buf_pd = {QDSC_NCH{w[QDSC_PD_BIT]}};
            st_next.buf_code = {QDSC_NCH{w[QDSC_CODE_HI:QDSC_CODE_LO]}};
          end
          load = '1;
        end
        default: begin
          load = '0;
        end
      endcase
    end

    // strobe rising edge: all channels from their buffers
    if (st_reg.strobe_s[1] & ~st_reg.strobe_prev) begin
      load = '1;
    end

    // transfer buffers; a power-down entry only changes the mode
    for (int i = 0; i < QDSC_NCH; i++) begin
      if (load[i]) begin
        if (st_next.buf_pd[i]) begin
          st_next.dac_mode[i] = {1'b1, st_next.buf_code[i][QDSC_CODE_W-1 -: 2]};
        end else begin
          st_next.dac_mode[i] = QDSC_MODE_NORMAL;
          st_next.dac_code[i] = st_next.buf_code[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  // idle levels on the link chains avoid a false edge at release
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
      st_reg.sclk_s <= 2'h3;
      st_reg.sclk_prev <= 1'b1;
      st_reg.sync_s <= 2'h3;
      st_reg.ref_en <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign o_dac_code = st_reg.dac_code;
  assign o_chan_mode = st_reg.dac_mode;
  assign o_ref_enabled = st_reg.ref_en;
  assign o_frame_done = st_reg.done;
endmodule // qdsc_dev

// ===== hdl/qdsc_host.sv
// Purpose: host serial master driven from avalon-mm registers
// Assumes: one frame at a time, sclk made by a divider of i_clk
// Notes: frame write while busy holds waitrequest until idle
`timescale 1ns/1ps
module qdsc_host
  import qdsc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  qdsc_link_if.host link,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {QDSC_IDLE, QDSC_SHIFT, QDSC_TAIL} qdsc_phase_t;
  typedef struct packed {
    qdsc_phase_t phase;
    logic [4:0] div;
    logic [4:0] bits;
    logic [QDSC_FRAME_W-1:0] sh;
    logic sclk;
    logic sync_n;
    logic din;
    logic mute;
    logic strobe;
    logic wait_q;
    logic [31:0] rdata;
  } qdsc_host_t;

  qdsc_host_t st_reg;
  qdsc_host_t st_next;

  // ----------------------------------------------------------------
  // bus slave and frame engine
  // ----------------------------------------------------------------
  always_comb begin
    logic busy;
    logic tick;
    busy = (st_reg.phase != QDSC_IDLE);
    tick = (st_reg.div == QDSC_SCLK_HALF - 5'h01);
    st_next = st_reg;
    st_next.wait_q = 1'b1;
    st_next.div = tick ? 5'h00 : st_reg.div + 5'h01;
    // serve once per request; a new frame waits for the old one
    if ((i_avs_read | i_avs_write) & st_reg.wait_q &
        !(i_avs_write & (i_avs_address == QDSC_REG_FRAME) & busy)) begin
      st_next.wait_q = 1'b0;
      st_next.rdata = '0;
      case (i_avs_address)
        QDSC_REG_FRAME: begin
          if (i_avs_write) begin
            st_next.phase = QDSC_SHIFT;
            st_next.sh = i_avs_writedata[QDSC_FRAME_W-1:0];
            st_next.sync_n = 1'b0;
            st_next.din = i_avs_writedata[QDSC_FRAME_W-1];
            st_next.div = '0;
            st_next.bits = '0;
          end
        end
        QDSC_REG_STATUS: begin
          st_next.rdata[0] = busy;
        end
        QDSC_REG_PINS: begin
          if (i_avs_write) begin
            st_next.mute = i_avs_writedata[QDSC_PIN_MUTE];
            st_next.strobe = i_avs_writedata[QDSC_PIN_STROBE];
          end
          st_next.rdata[QDSC_PIN_MUTE] = st_reg.mute;
          st_next.rdata[QDSC_PIN_STROBE] = st_reg.strobe;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end
    // clock idles high; data changes after each rising edge but the 24th
    case (st_reg.phase)
      QDSC_SHIFT: begin
        if (tick) begin
          st_next.sclk = ~st_reg.sclk;
          if (!st_reg.sclk) begin
            if (st_reg.bits == QDSC_LAST_FALL - 5'h01) begin
              st_next.phase = QDSC_TAIL;
            end else begin
              st_next.bits = st_reg.bits + 5'h01;
              st_next.sh = {st_reg.sh[QDSC_FRAME_W-2:0], 1'b0};
              st_next.din = st_reg.sh[QDSC_FRAME_W-2];
            end
          end
        end
      end
      QDSC_TAIL: begin
        // sync rises only after all 24 falling edges
        if (tick) begin
          st_next.sync_n = 1'b1;
          st_next.phase = QDSC_IDLE;
        end
      end
      default: begin
        st_next.sclk = 1'b1;
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg <= '0;
      st_reg.phase <= QDSC_IDLE;
      st_reg.sclk <= 1'b1;
      st_reg.sync_n <= 1'b1;
      st_reg.wait_q <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // all lines driven to defined levels at all times
  assign link.sclk = st_reg.sclk;
  assign link.frame_sync_n = st_reg.sync_n;
  assign link.ser_data = st_reg.din;
  assign link.port_mute = st_reg.mute;
  assign link.async_load_strobe = st_reg.strobe;
  assign o_avs_readdata = st_reg.rdata;
  assign o_avs_waitrequest = st_reg.wait_q;
endmodule // qdsc_host

// ===== sim/qdsc_link_monitor.sv
// Purpose: link checks between host and converter ends
// Assumes: one i_clk domain, async active-low reset
// Notes: watches the first link only
`timescale 1ns/1ps
module qdsc_link_monitor
  import qdsc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic sclk,
  input wire logic frame_sync_n,
  input wire logic ser_data,
  input wire logic port_mute,
  input wire logic async_load_strobe,
  input wire logic o_frame_done
);
  // ---
  // falls seen in the current frame
  // ---
  logic [4:0] falls_reg;
  logic sclk_reg;
  // cleared while sync is high so an old count never leaks on
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      falls_reg <= 5'h00;
      sclk_reg <= 1'b1;
    end else begin
      sclk_reg <= sclk;
      if (frame_sync_n) begin
        falls_reg <= 5'h00;
      end else if (sclk_reg && !sclk) begin
        falls_reg <= falls_reg + 5'h01;
      end
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  idle_sclk_a: assert property (frame_sync_n |-> sclk)
    else $error("sclk low outside a frame");
  sync_lead_a: assert property ($fell(frame_sync_n) |-> ##16 $fell(sclk))
    else $error("first fall not 16 clocks after sync");
  half_period_a: assert property ($fell(sclk) |-> ##16 $rose(sclk))
    else $error("sclk low half period wrong");
  data_stable_a: assert property (!sclk |-> $stable(ser_data))
    else $error("data moved while sclk low");
  frame_len_a: assert property ($rose(frame_sync_n) |-> falls_reg == QDSC_LAST_FALL)
    else $error("frame not 24 falls");
  no_extra_a: assert property (falls_reg == QDSC_LAST_FALL |-> !$fell(sclk))
    else $error("fall after the last bit");
  done_late_a: assert property (o_frame_done |-> falls_reg == QDSC_LAST_FALL)
    else $error("frame acted before 24 falls");
  done_pulse_a: assert property (o_frame_done |=> !o_frame_done)
    else $error("frame done longer than a cycle");
  cover property ($rose(frame_sync_n));
  cover property (o_frame_done);
  cover property ($rose(async_load_strobe));
  cover property (port_mute && $fell(sclk));
endmodule // qdsc_link_monitor

// ===== sim/tb.sv
// Purpose: host and converter ends joined, driven over avalon
// Assumes: straps 00, second converter end bit-banged by the bench
// Notes: expected values worked out by hand per row
`timescale 1ns/1ps
module tb import qdsc_pkg::*;;
  typedef struct packed {logic [23:0] f; logic [68:0] e;} qdsc_row_t;
  localparam logic [13:0] abc = 14'h0abc;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [3:0] av_addr = 4'h0;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_wd = 32'h0;
  logic [31:0] rdata, rd_w;
  logic wreq, ref_on, done;
  logic [55:0] code, code2;
  logic [11:0] mode;
  int mismatches = 0;
  int num_checks = 0;
  qdsc_row_t rows [12];
  qdsc_link_if link();
  qdsc_link_if link2();
  // ---
  // clock and instances
  // ---
  always #2.5 i_clk = ~i_clk;
  qdsc_host qdsc_host_inst (.i_clk(i_clk), .i_nrst(i_nrst), .link(link.host),
    .i_avs_address(av_addr), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wd), .o_avs_readdata(rd_w), .o_avs_waitrequest(wreq));
  qdsc_dev qdsc_dev_inst (.i_clk(i_clk), .i_nrst(i_nrst), .link(link.dev),
    .i_dev_addr_hi(1'b0), .i_dev_addr_lo(1'b0), .o_dac_code(code),
    .o_chan_mode(mode), .o_ref_enabled(ref_on), .o_frame_done(done));
  // second end lets the bench cut a frame short
  qdsc_dev qdsc_dev_inst2 (.i_clk(i_clk), .i_nrst(i_nrst), .link(link2.dev),
    .i_dev_addr_hi(1'b0), .i_dev_addr_lo(1'b0), .o_dac_code(code2),
    .o_chan_mode(), .o_ref_enabled(), .o_frame_done());
  qdsc_link_monitor qdsc_link_monitor_inst (.i_clk(i_clk), .i_nrst(i_nrst),
    .sclk(link.sclk), .frame_sync_n(link.frame_sync_n), .ser_data(link.ser_data),
    .port_mute(link.port_mute), .async_load_strobe(link.async_load_strobe),
    .o_frame_done(done));
  // ---
  // helpers
  // ---
  function automatic logic [23:0] fr(input logic [1:0] a, c, s, input logic p,
                                     input logic [13:0] d);
    return {a, c, 1'b0, s, p, d, 2'b00};
  endfunction
  function automatic logic [68:0] ex(input logic [13:0] c3, c2, c1, c0,
                                     input logic [11:0] m);
    return {c3, c2, c1, c0, m, 1'b1};
  endfunction
  task automatic tally_and_finish;
    if (mismatches == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [68:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk);
    av_wr <= w;
    av_rd <= ~w;
    av_addr <= a;
    av_wd <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (wreq !== 1'b0 && n < 2000);
    rdata = rd_w;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    if (wreq !== 1'b0) begin mismatches++; tally_and_finish(); end
  endtask
  task automatic send(input logic [23:0] f);
    int n;
    n = 0;
    bus(1'b1, QDSC_REG_FRAME, {8'h00, f});
    do begin
      bus(1'b0, QDSC_REG_STATUS, 32'h0);
      n++;
    end while (rdata[0] !== 1'b0 && n < 1000);
    if (rdata[0] !== 1'b0) begin mismatches++; tally_and_finish(); end
    repeat (8) @(posedge i_clk);
  endtask
  // sends the first n bits msb first, 160 ns link period
  task automatic bang(input logic [23:0] f, input int n);
    link2.frame_sync_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      link2.ser_data <= f[23-i];
      repeat (16) @(posedge i_clk);
      link2.sclk <= 1'b0;
      repeat (16) @(posedge i_clk);
      link2.sclk <= 1'b1;
    end
    repeat (16) @(posedge i_clk);
    link2.frame_sync_n <= 1'b1;
    link2.ser_data <= ~link2.ser_data;
    repeat (16) @(posedge i_clk);
  endtask
  // ---
  // main sequence
  // ---
  initial begin
    link2.sclk = 1'b1;
    link2.frame_sync_n = 1'b1;
    link2.ser_data = 1'b0;
    link2.port_mute = 1'b0;
    link2.async_load_strobe = 1'b0;
    rows[0] = '{fr(0, 0, 0, 0, 14'h1111), ex(0, 0, 0, 0, 12'h000)};
    rows[1] = '{fr(0, 1, 1, 0, 14'h2222), ex(0, 0, 14'h2222, 0, 12'h000)};
    rows[2] = '{fr(0, 2, 2, 0, 14'h3333), ex(0, 14'h3333, 14'h2222, 14'h1111, 12'h000)};
    rows[3] = '{fr(3, 3, 2, 0, abc), ex(abc, abc, abc, abc, 12'h000)};
    rows[4] = '{fr(0, 1, 3, 1, 14'h1000), ex(abc, abc, abc, abc, 12'ha00)};
    rows[5] = '{fr(0, 0, 0, 0, 14'h0123), ex(abc, abc, abc, abc, 12'ha00)};
    rows[6] = '{fr(2, 3, 0, 0, 14'h3fff), ex(abc, abc, abc, 14'h0123, 12'ha00)};
    rows[7] = '{fr(0, 3, 2, 1, 14'h2000), ex(abc, abc, abc, 14'h0123, 12'hdb6)};
    rows[8] = '{fr(0, 2, 0, 1, 14'h3000), ex(abc, abc, abc, 14'h0123, 12'hdb7)};
    rows[9] = '{fr(0, 1, 1, 0, 14'h1234), ex(abc, abc, 14'h1234, 14'h0123, 12'hd87)};
    rows[10] = '{fr(1, 1, 2, 0, 14'h0555), rows[9].e};
    rows[11] = '{fr(0, 1, 2, 0, 14'h0555) | 24'h080000, rows[9].e};
    repeat (20) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk({code, mode, ref_on}, ex(0, 0, 0, 0, 12'h000));
    foreach (rows[i]) begin
      send(rows[i].f);
      chk({code, mode, ref_on}, rows[i].e);
    end
    // store only, then a strobe edge moves buffers out
    send(fr(0, 0, 2, 0, 14'h0777));
    chk({code, mode, ref_on}, rows[9].e);
    bus(1'b1, QDSC_REG_PINS, 32'h2);
    bus(1'b1, QDSC_REG_PINS, 32'h0);
    repeat (8) @(posedge i_clk);
    chk({code, mode, ref_on}, ex(abc, 14'h0777, 14'h1234, 14'h0123, 12'hc07));
    bus(1'b1, QDSC_REG_PINS, 32'h1);
    send(fr(0, 1, 0, 0, 14'h0001));
    bus(1'b1, QDSC_REG_PINS, 32'h0);
    chk({code, mode, ref_on}, ex(abc, 14'h0777, 14'h1234, 14'h0123, 12'hc07));
    bang(fr(0, 1, 0, 0, 14'h0042), 23);
    chk({13'h0, code2}, 69'h0);
    bang(fr(0, 1, 0, 0, 14'h0042), 24);
    chk({13'h0, code2}, 69'h42);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk({code, mode, ref_on}, ex(0, 0, 0, 0, 12'h000));
    tally_and_finish();
  end
endmodule // tb
